// ---- sim/apsc_assertions.sv ----
/* port checker of apsc_top
   bound by the bench; one clock domain */
`timescale 1ns/1ns
module apsc_assertions #(
  parameter int CONV_CYCLES = 60
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // watched ports
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic bus_oe_ff,
  input wire logic completion_n_ff,
  input wire logic [1:0] conv_channel_ff,
  input wire logic conv_active_ff,
  input wire logic hold_ff,
  input wire logic adc_enable_ff,
  input wire logic ref_buf_enable_ff,
  input wire apsc_pkg::apsc_ctrl_t ctrl_ff,
  input wire logic ready_ff
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic [3:0] rd_age_ff; // cycles since a read, saturating
  logic [3:0] nxt_rd_age;
  logic [7:0] act_ff; // cycles the sequence ran
  logic [7:0] nxt_act;
  // age and length counters
  always_comb begin
    nxt_rd_age = (rd_age_ff == 4'hf) ? rd_age_ff : rd_age_ff + 4'h1;
    if (!cs_n && !rd_n) nxt_rd_age = 4'h0;
    nxt_act = conv_active_ff ? act_ff + 8'h1 : 8'h0;
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_age_ff <= 4'hf;
      act_ff <= 8'h0;
    end else begin
      rd_age_ff <= nxt_rd_age;
      act_ff <= nxt_act;
    end
  end
  // normal end of a sequence, not an abort
  sequence seq_done;
    $fell(conv_active_ff) ##0 !ctrl_ff.powerdown_bit;
  endsequence
  chk_pd_off: assert property (ctrl_ff.powerdown_bit |-> !adc_enable_ff && !ref_buf_enable_ff)
    else $error("converter enabled in power-down");
  chk_pd_idle: assert property (ctrl_ff.powerdown_bit |-> !ready_ff)
    else $error("ready in power-down");
  chk_wake_on: assert property ($fell(ctrl_ff.powerdown_bit) |-> adc_enable_ff)
    else $error("no wake");
  chk_flag_end: assert property (seq_done |-> !completion_n_ff)
    else $error("flag not set at end");
  chk_seq_len: assert property (seq_done |-> int'(act_ff) == (int'(ctrl_ff.cnt_m1) + 1) * CONV_CYCLES)
    else $error("sequence length wrong");
  chk_flag_clear: assert property ($rose(completion_n_ff) |-> rd_age_ff < 4'h8)
    else $error("flag cleared without read");
  chk_oe_read: assert property (bus_oe_ff |-> rd_age_ff < 4'h8)
    else $error("bus driven without read");
  chk_oe_on: assert property ((!cs_n && !rd_n && wr_n) [*6] |-> bus_oe_ff)
    else $error("bus not driven during read");
  chk_seq_start: assert property ($rose(conv_active_ff) |-> hold_ff && conv_channel_ff == 2'h0)
    else $error("bad sequence start");
  chk_chan_step: assert property (conv_active_ff && $past(conv_active_ff) && $changed(conv_channel_ff)
    |-> conv_channel_ff == $past(conv_channel_ff) + 2'h1)
    else $error("channel skipped");
endmodule // apsc_assertions

// ---- sim/apsc_host_model.sv ----
/* host side of the parallel bus
   assumes a read answer within eight clock edges */
`timescale 1ns/1ns
module apsc_host_model (
  // clock
  input wire logic ref_clk,
  // strobes and bus to the device
  output logic cs_n,
  output logic wr_n,
  output logic rd_n,
  output logic sample_trigger_n,
  output logic [13:0] bus_i,
  // read data back
  input wire logic [13:0] bus_o_ff
);
  // idle pins
  initial begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    sample_trigger_n = 1'b1;
    bus_i = 14'h2aaa;
  end
  // pins move just after a falling edge
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // control write, data held well past the strobe end
  task automatic wr_word(input logic [3:0] w);
    cyc(1);
    bus_i = {10'h0, w};
    cs_n = 1'b0;
    wr_n = 1'b0;
    cyc(6);
    wr_n = 1'b1;
    cs_n = 1'b1;
    cyc(6);
    bus_i = ~bus_i; // driven to its complement: no stale value
    cyc(2);
  endtask
  // reads under one select
  task automatic rd_burst(input int n, output logic [13:0] q [5]);
    cyc(1);
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      rd_n = 1'b0;
      cyc(8);
      q[i] = bus_o_ff;
      rd_n = 1'b1;
      cyc(8);
    end
    cs_n = 1'b1;
  endtask
  task automatic trig();
    cyc(1);
    sample_trigger_n = 1'b0;
    cyc(6);
    sample_trigger_n = 1'b1;
    cyc(2);
  endtask
  // 5 us power-up delay after a wake word
  task automatic wake_wait();
    cyc(100);
  endtask
endmodule // apsc_host_model

// ---- sim/tb_adc_power_state_control.sv ----
/* bench of apsc_top with host model and random results
   assumes design and checker compile first */
`timescale 1ns/1ns
module tb_adc_power_state_control;
  logic ref_clk, reset_n, cs_n, wr_n, rd_n, trig_n, oe, flag_n, active, hold, bank;
  logic adc_en, ref_en, ready;
  logic [13:0] bus_i, bus_o, conv_data;
  logic [1:0] chan;
  apsc_pkg::apsc_ctrl_t ctrl;
  logic [13:0] dat [4]; // offset-binary core result per channel
  logic [13:0] q [5];
  int err_total, checked, seed;
  assign conv_data = dat[chan];
  apsc_top #(.CONV_CYCLES(3), .POR_CYCLES(4)) u_dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .sample_trigger_n(trig_n), .bus_i(bus_i),
    .bus_o_ff(bus_o), .bus_oe_ff(oe), .completion_n_ff(flag_n), .conv_data_i(conv_data),
    .conv_channel_ff(chan), .conv_bank_ff(bank), .conv_active_ff(active), .hold_ff(hold),
    .adc_enable_ff(adc_en), .ref_buf_enable_ff(ref_en), .ctrl_ff(ctrl), .ready_ff(ready));
  apsc_host_model u_host (.ref_clk(ref_clk), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
    .sample_trigger_n(trig_n), .bus_i(bus_i), .bus_o_ff(bus_o));
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // offset binary to two's complement
  function automatic logic [15:0] code(input logic [13:0] raw);
    return {2'h0, raw ^ 14'h2000};
  endfunction
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // trigger, then read n+1 words to see the wrap
  task automatic run_seq(input int n);
    foreach (dat[i]) dat[i] = 14'($random(seed));
    u_host.trig();
    wait (flag_n === 1'b0);
    u_host.rd_burst(n + 1, q);
    for (int k = 0; k < n; k++) chk("data", code(dat[k]), {2'h0, q[k]});
    chk("wrap", code(dat[0]), {2'h0, q[n]});
    chk("flag after read", 16'h1, {15'h0, flag_n});
  endtask
  // 50 ns clock, even duty
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    test_done();
  end
  initial begin
    seed = 32'h4ab06cf0;
    reset_n = 1'b0;
    dat = '{default: 14'h0};
    repeat (3) @(negedge ref_clk);
    reset_n = 1'b1;
    chk("flag after reset", 16'h1, {15'h0, flag_n});
    chk("mode after reset", 16'h0, {12'h0, ctrl});
    chk("ready after reset", 16'h0, {15'h0, ready});
    wait (ready === 1'b1);
    // every bank and channel count
    for (int m = 0; m < 8; m++) begin
      u_host.wr_word(4'(m));
      chk("mode", 16'(m), {12'h0, ctrl});
      run_seq(m % 4 + 1);
      chk("bank", 16'(m / 4), {15'h0, bank});
    end
    u_host.wr_word({1'b1, 3'($random(seed))});
    chk("pd bit", 16'h1, {15'h0, ctrl.powerdown_bit});
    chk("adc off", 16'h0, {14'h0, adc_en, ref_en});
    u_host.trig();
    u_host.cyc(30);
    chk("pd trigger", 16'h1, {14'h0, active, flag_n});
    u_host.wr_word(4'h6);
    chk("wake mode", 16'h6, {12'h0, ctrl});
    chk("adc on", 16'h3, {14'h0, adc_en, ref_en});
    u_host.wake_wait();
    run_seq(3);
    test_done();
  end
endmodule // tb_adc_power_state_control
bind apsc_top apsc_assertions #(.CONV_CYCLES(CONV_CYCLES)) u_chk (.ref_clk(ref_clk),
  .reset_n(reset_n), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .bus_oe_ff(bus_oe_ff),
  .completion_n_ff(completion_n_ff), .conv_channel_ff(conv_channel_ff),
  .conv_active_ff(conv_active_ff), .hold_ff(hold_ff), .adc_enable_ff(adc_enable_ff),
  .ref_buf_enable_ff(ref_buf_enable_ff), .ctrl_ff(ctrl_ff), .ready_ff(ready_ff));

// ---- src/apsc_consts.svh ----
/*
  constants of the converter power-state control: control word fields, reset values and timing
  assumes a 50 ns core clock; the cycle counts are derived from the nominal times
*/
`ifndef APSC_CONSTS_SVH
`define APSC_CONSTS_SVH

// control word field positions on the low bus lines
`define APSC_PD_BIT 3
`define APSC_BANK_BIT 2
`define APSC_CNT_HI 1
`define APSC_CNT_LO 0

// reset values: bank a, one channel, powered up
`define APSC_RST_PD 1'b0
`define APSC_RST_BANK 1'b0
`define APSC_RST_CNT 2'h0

// timing, nominal times in ns
`define APSC_CLK_PERIOD_NS 50
`define APSC_CONV_TIME_NS 3000
`define APSC_POR_TIME_NS 5000
// least times round up to whole cycles
`define APSC_CONV_CYCLES ((`APSC_CONV_TIME_NS + `APSC_CLK_PERIOD_NS - 1) / `APSC_CLK_PERIOD_NS)
`define APSC_POR_CYCLES ((`APSC_POR_TIME_NS + `APSC_CLK_PERIOD_NS - 1) / `APSC_CLK_PERIOD_NS)

// data word width of one result
`define APSC_DATA_W 14

`endif

// ---- src/apsc_pkg.sv ----
/*
  types of the converter power-state control
  assumes apsc_consts.svh is on the include path
*/
package apsc_pkg;

  // decoded control word
  typedef struct packed {
    logic powerdown_bit;   // 1 = software power-down
    logic bank_select_bit; // 0 = bank a, 1 = bank b
    logic [1:0] cnt_m1;    // channel count minus one
  } apsc_ctrl_t;

  // sequencer states
  typedef enum logic [1:0] {
    ST_POR,
    ST_IDLE,
    ST_CONV
  } apsc_state_t;

endpackage

// ---- src/apsc_sync3.sv ----
/*
  three-stage pin synchroniser with agreement filter
  assumes asynchronous pin inputs; output is a registered clean level
*/
`timescale 1ns/1ns
module apsc_sync3 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // raw pins and clean levels
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level_ff
);
  logic [W-1:0] s1_ff; // first stage, read only by s2
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] nxt_level;

  // a bit changes only once stages two and three agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      nxt_level[i] = (s2_ff[i] == s3_ff[i]) ? s2_ff[i] : level_ff[i];
    end
  end

  // idle pins are high (strobes inactive), so reset to ones
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_ff <= '1;
      s2_ff <= '1;
      s3_ff <= '1;
      level_ff <= '1;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      level_ff <= nxt_level;
    end
  end
endmodule // apsc_sync3

// ---- src/apsc_top.sv ----
/*
  control logic of a two-bank simultaneous-sampling converter: power-on, power-down, sequencing,
  result memory and parallel read-out
  assumes strobes come from an outside processor; the converter core supplies offset-binary data
*/
`include "apsc_consts.svh"
`timescale 1ns/1ns
module apsc_top #(
  parameter int CONV_CYCLES = `APSC_CONV_CYCLES,
  parameter int POR_CYCLES = `APSC_POR_CYCLES,
  parameter int DW = `APSC_DATA_W
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // parallel bus pins
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic sample_trigger_n,
  input wire logic [DW-1:0] bus_i,
  output logic [DW-1:0] bus_o_ff,
  output logic bus_oe_ff,
  output logic completion_n_ff,
  // converter core side
  input wire logic [DW-1:0] conv_data_i,
  output logic [1:0] conv_channel_ff,
  output logic conv_bank_ff,
  output logic conv_active_ff,
  output logic hold_ff,
  output logic adc_enable_ff,
  output logic ref_buf_enable_ff,
  // status
  output apsc_pkg::apsc_ctrl_t ctrl_ff,
  output logic ready_ff
);
  // counters are 16 bits; refuse counts they cannot hold
  if (CONV_CYCLES < 1 || CONV_CYCLES > 65535) $error("CONV_CYCLES out of range");
  if (POR_CYCLES < 1 || POR_CYCLES > 65535) $error("POR_CYCLES out of range");
  if (DW < 4) $error("DW must cover the control word");

  // synchronised pins: trigger, read, write, select, four control lines
  logic [7:0] pins_raw;
  logic [7:0] pins_ff;
  assign pins_raw = {sample_trigger_n, rd_n, wr_n, cs_n, bus_i[3:0]};

  apsc_sync3 #(.W(8)) u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pin(pins_raw),
    .level_ff(pins_ff)
  );

  logic trig_n;      // clean trigger level
  logic write_act;   // select and write both low
  logic read_act;    // select and read low, write high
  logic [3:0] cw;    // clean control lines
  assign trig_n = pins_ff[7];
  assign read_act = ~pins_ff[4] & ~pins_ff[6] & pins_ff[5];
  assign write_act = ~pins_ff[4] & ~pins_ff[5];
  assign cw = pins_ff[3:0];

  // state
  apsc_pkg::apsc_state_t state_ff, nxt_state;
  logic [15:0] cnt_ff, nxt_cnt;      // reset interval and per-channel timer
  logic [1:0] ptr_ff, nxt_ptr;       // read-out pointer
  logic trig_prev_ff, nxt_trig_prev; // edge detect history
  logic write_prev_ff, nxt_write_prev;
  logic read_prev_ff, nxt_read_prev;
  logic [3:0] cw_hold_ff, nxt_cw_hold; // lines seen while write active
  logic first_rd_ff, nxt_first_rd;   // no read since completion yet
  apsc_pkg::apsc_ctrl_t nxt_ctrl;
  logic [DW-1:0] nxt_bus_o;
  logic nxt_bus_oe, nxt_completion_n, nxt_ready;
  logic [1:0] nxt_channel;
  logic nxt_bank, nxt_active, nxt_hold, nxt_adc_en, nxt_ref_en;

  // result memory, one word per channel
  logic [DW-1:0] mem [4];
  logic mem_we;
  logic [DW-1:0] mem_wdata;

  logic trig_rise, write_end, read_fall, read_rise, chan_done;
  logic seq_end; // last channel of a sequence finishes this cycle
  assign trig_rise = trig_n & ~trig_prev_ff;
  assign write_end = write_prev_ff & ~write_act;
  assign read_fall = read_act & ~read_prev_ff;
  assign read_rise = read_prev_ff & ~read_act;
  assign chan_done = (state_ff == apsc_pkg::ST_CONV) && (cnt_ff == 16'(CONV_CYCLES - 1));

  // sequencer, control word and read-out
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_ptr = ptr_ff;
    nxt_trig_prev = trig_n;
    nxt_write_prev = write_act;
    nxt_read_prev = read_act;
    nxt_cw_hold = write_act ? cw : cw_hold_ff;
    nxt_first_rd = first_rd_ff;
    nxt_ctrl = ctrl_ff;
    nxt_completion_n = completion_n_ff;
    nxt_channel = conv_channel_ff;
    nxt_bank = conv_bank_ff;
    nxt_active = 1'b0;
    nxt_hold = hold_ff;
    seq_end = 1'b0;
    mem_we = 1'b0;
    // core delivers offset binary; flipping the sign bit gives two's complement
    mem_wdata = {~conv_data_i[DW-1], conv_data_i[DW-2:0]};

    // latch the lines at the edge that ends the write, whichever strobe rises
    if (write_end) begin
      nxt_ctrl.powerdown_bit = nxt_cw_hold[`APSC_PD_BIT];
      if (!nxt_cw_hold[`APSC_PD_BIT]) begin
        // wake or reprogram: take bank and count
        nxt_ctrl.bank_select_bit = nxt_cw_hold[`APSC_BANK_BIT];
        nxt_ctrl.cnt_m1 = nxt_cw_hold[`APSC_CNT_HI:`APSC_CNT_LO];
      end
    end

    unique case (state_ff)
      apsc_pkg::ST_POR: begin
        // triggers are not honoured until the reset interval has run
        if (cnt_ff == 16'(POR_CYCLES - 1)) begin
          nxt_state = apsc_pkg::ST_IDLE;
          nxt_cnt = 16'h0000;
        end else begin
          nxt_cnt = cnt_ff + 16'h0001;
        end
      end
      apsc_pkg::ST_IDLE: begin
        // powered-down trigger leaves flag and memory alone
        if (trig_rise && !ctrl_ff.powerdown_bit) begin
          nxt_state = apsc_pkg::ST_CONV;
          nxt_cnt = 16'h0000;
          nxt_channel = 2'h0;
          nxt_bank = ctrl_ff.bank_select_bit;
          nxt_hold = 1'b1;
          nxt_active = 1'b1;
          nxt_ptr = 2'h0;
        end
      end
      apsc_pkg::ST_CONV: begin
        // further triggers ignored until the sequence ends
        nxt_active = 1'b1;
        if (ctrl_ff.powerdown_bit) begin
          // power-down mid-sequence abandons it; flag stays as it was
          nxt_state = apsc_pkg::ST_IDLE;
          nxt_active = 1'b0;
          nxt_hold = 1'b0;
        end else if (chan_done) begin
          mem_we = 1'b1;
          nxt_cnt = 16'h0000;
          if (conv_channel_ff == ctrl_ff.cnt_m1) begin
            nxt_state = apsc_pkg::ST_IDLE;
            nxt_active = 1'b0;
            nxt_hold = 1'b0;
            nxt_completion_n = 1'b0;
            nxt_first_rd = 1'b1;
            seq_end = 1'b1;
          end else begin
            nxt_channel = conv_channel_ff + 2'h1;
          end
        end else begin
          nxt_cnt = cnt_ff + 16'h0001;
        end
      end
      default: nxt_state = apsc_pkg::ST_IDLE;
    endcase

    // read side: first read clears the flag; a completion in the same cycle wins,
    // so a fresh result set is never announced and lost in one step
    if (read_fall && first_rd_ff && !seq_end) begin
      nxt_completion_n = 1'b1;
      nxt_first_rd = 1'b0;
    end
    if (read_rise) begin
      nxt_ptr = (ptr_ff == ctrl_ff.cnt_m1) ? 2'h0 : ptr_ff + 2'h1;
    end

    // bus keeps working in power-down so a wake word gets through
    nxt_bus_oe = read_act;
    nxt_bus_o = mem[nxt_ptr];
    nxt_ready = (nxt_state == apsc_pkg::ST_IDLE) && !nxt_ctrl.powerdown_bit;
    nxt_adc_en = !nxt_ctrl.powerdown_bit;
    nxt_ref_en = !nxt_ctrl.powerdown_bit;
  end

  // register everything; reset lands in bank a single-channel with flag high
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= apsc_pkg::ST_POR;
      cnt_ff <= 16'h0000;
      ptr_ff <= 2'h0;
      trig_prev_ff <= 1'b1;
      write_prev_ff <= 1'b0;
      read_prev_ff <= 1'b0;
      cw_hold_ff <= 4'h0;
      first_rd_ff <= 1'b0;
      ctrl_ff <= '{`APSC_RST_PD, `APSC_RST_BANK, `APSC_RST_CNT};
      completion_n_ff <= 1'b1;
      conv_channel_ff <= 2'h0;
      conv_bank_ff <= 1'b0;
      conv_active_ff <= 1'b0;
      hold_ff <= 1'b0;
      adc_enable_ff <= 1'b1;
      ref_buf_enable_ff <= 1'b1;
      bus_o_ff <= '0;
      bus_oe_ff <= 1'b0;
      ready_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      ptr_ff <= nxt_ptr;
      trig_prev_ff <= nxt_trig_prev;
      write_prev_ff <= nxt_write_prev;
      read_prev_ff <= nxt_read_prev;
      cw_hold_ff <= nxt_cw_hold;
      first_rd_ff <= nxt_first_rd;
      ctrl_ff <= nxt_ctrl;
      completion_n_ff <= nxt_completion_n;
      conv_channel_ff <= nxt_channel;
      conv_bank_ff <= nxt_bank;
      conv_active_ff <= nxt_active;
      hold_ff <= nxt_hold;
      adc_enable_ff <= nxt_adc_en;
      ref_buf_enable_ff <= nxt_ref_en;
      bus_o_ff <= nxt_bus_o;
      bus_oe_ff <= nxt_bus_oe;
      ready_ff <= nxt_ready;
    end
  end

  // results are not reset: a word stays undefined until its channel first finishes a conversion
  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem[conv_channel_ff] <= mem_wdata;
    end
  end
endmodule // apsc_top
